// ---- logic/bridge_device.sv ----
// Device end: sleep, revision read and packet CRC-16 checking
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RULE_01: Sleep command puts device into sleep
// RULE_02: Sleeping device ignores all bus traffic
// RULE_03: Only a wake rising edge ends sleep
// RULE_04: Host sends no reads after sleep
// RULE_05: Revision byte: major high, minor low nibble
// RULE_06: Host resets and addresses before commands
// RULE_07: Node ID top byte is CRC8
// RULE_08: CRC8 polynomial x8+x5+x4+1, sent true
// RULE_09: Packet PACKET_CRC_ERROR_FLAG polynomial x16+x15+x2+1
// RULE_10: PACKET_CRC_ERROR_FLAG is carried inverted on bus
// RULE_11: CRC mismatch sets flag, skips I2C
// RULE_12: Error flag drives error output high
// RULE_13: CRC covers command, address, lengths, data; code zeroes address bit 0 before folding it into the CRC
// RULE_14: Mismatch sets status bit0, write status FFh
// RULE_15: Error output held until bus reset
// RULE_16: PACKET_CRC_ERROR_FLAG starts zero, shifts LSB first
module bridge_device
  import bridge_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             arst_n,
  bridge_link_if.device         link,
  input  wire logic [55:0]      node_serial,
  output logic                  error_detected_out,
  output logic                  sleeping,
  output logic                  i2c_go,
  output logic [7:0]            i2c_address,
  output logic [63:0]           node_identifier
);
  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0000,
    ST_ROM     = 4'b0001,
    ST_CMD     = 4'b0010,
    ST_ADDR    = 4'b0011,
    ST_WLEN    = 4'b0100,
    ST_WDATA   = 4'b0101,
    ST_RCNT    = 4'b0110,
    ST_CRC_LO  = 4'b0111,
    ST_CRC_HI  = 4'b1000,
    ST_REPLY   = 4'b1001,
    ST_SLEEP   = 4'b1010,
    ST_WAIT    = 4'b1011
  } state_t;

  state_t      state;
  logic [15:0] crc;
  logic [7:0]  crc_lo;
  logic [7:0]  write_left;
  logic        wake_prev;
  logic        packet_crc_error_flag;
  logic [1:0]  reply_left;
  logic [7:0]  reply_a;
  logic [7:0]  reply_b;
  logic [7:0]  node_crc;
  logic        wr_ready_q;

  wire         take      = link.wr_valid & wr_ready_q;
  wire [7:0]   b         = link.wr_byte;
  wire [15:0]  next_crc  = packet_crc_error_flag_byte(crc, b); // RULE_09 RULE_16
  wire [7:0]   addr_crc  = {b[7:1], 1'b0}; // RULE_13
  wire         wake_rise = link.wake & ~wake_prev; // RULE_03
  wire [15:0]  rx_crc    = ~{b, crc_lo}; // RULE_10
  wire         crc_ok    = (rx_crc == crc); // RULE_11

  // Node ID CRC folded over the 56 serial bits, true form on top
  always_comb begin
    node_crc = CRC8_INIT;
    for (int i = 0; i < 7; i++) begin
      node_crc = crc8_byte(node_crc, node_serial[i*8 +: 8]); // RULE_08
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      node_identifier <= 64'h0000000000000000;
    end else begin
      node_identifier <= {node_crc, node_serial}; // RULE_07
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wake_prev <= 1'b0;
    end else begin
      wake_prev <= link.wake;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state                 <= ST_IDLE;
      crc                   <= PACKET_CRC_ERROR_FLAG_INIT;
      crc_lo                <= 8'h00;
      write_left            <= 8'h00;
      packet_crc_error_flag <= 1'b0;
      error_detected_out    <= 1'b0;
      sleeping              <= 1'b0;
      i2c_go                <= 1'b0;
      i2c_address           <= 8'h00;
      reply_left            <= 2'h0;
      reply_a               <= 8'h00;
      reply_b               <= 8'h00;
      wr_ready_q            <= 1'b0;
      link.presence         <= 1'b0;
      link.rd_valid         <= 1'b0;
      link.rd_byte          <= 8'h00;
    end else begin
      i2c_go        <= 1'b0;
      link.presence <= 1'b0;
      link.rd_valid <= 1'b0;
      wr_ready_q    <= (state != ST_SLEEP);
      if (state == ST_SLEEP) begin
        // Bus reset and bytes are deliberately dropped here
        wr_ready_q <= 1'b0; // RULE_02
        if (wake_rise) begin
          state    <= ST_IDLE; // RULE_03
          sleeping <= 1'b0;
        end
      end else if (link.bus_reset) begin
        // Reset also aborts any packet in flight
        state                 <= ST_ROM;
        link.presence         <= 1'b1;
        packet_crc_error_flag <= 1'b0; // RULE_15
        error_detected_out    <= 1'b0; // RULE_15
        reply_left            <= 2'h0;
      end else begin
        unique case (state)
          ST_IDLE, ST_WAIT: ;
          ST_ROM:
            if (take) begin
              state <= (b == ROM_SKIP) ? ST_CMD : ST_WAIT;
            end
          ST_CMD:
            if (take) begin
              crc <= next_crc; // RULE_13
              if (b == CMD_SLEEP) begin
                state      <= ST_SLEEP; // RULE_01
                sleeping   <= 1'b1;
                wr_ready_q <= 1'b0;
              end else if (b == CMD_REVISION) begin
                reply_a    <= {REV_MAJOR, REV_MINOR}; // RULE_05
                reply_left <= 2'h1;
                state      <= ST_REPLY;
              end else if (b == CMD_I2C_WRITE_READ) begin
                state <= ST_ADDR;
              end else begin
                state <= ST_WAIT;
              end
            end
          ST_ADDR:
            if (take) begin
              crc         <= packet_crc_error_flag_byte(crc, addr_crc); // RULE_13
              i2c_address <= b;
              state       <= ST_WLEN;
            end
          ST_WLEN:
            if (take) begin
              crc        <= next_crc;
              write_left <= b;
              state      <= (b == 8'h00) ? ST_RCNT : ST_WDATA;
            end
          ST_WDATA:
            if (take) begin
              crc        <= next_crc;
              write_left <= write_left - 8'h01;
              if (write_left == 8'h01) begin
                state <= ST_RCNT;
              end
            end
          ST_RCNT:
            if (take) begin
              crc   <= next_crc;
              state <= ST_CRC_LO;
            end
          ST_CRC_LO:
            if (take) begin
              crc_lo <= b;
              state  <= ST_CRC_HI;
            end
          ST_CRC_HI:
            if (take) begin
              reply_left <= 2'h2;
              state      <= ST_REPLY;
              if (crc_ok) begin
                i2c_go  <= 1'b1; // RULE_11
                reply_a <= STATUS_CLEAR;
                reply_b <= 8'h00;
              end else begin
                packet_crc_error_flag <= 1'b1; // RULE_11
                error_detected_out    <= 1'b1; // RULE_12
                reply_a    <= STATUS_CLEAR | (8'h01 << STATUS_CRC_BIT); // RULE_14
                reply_b    <= WRITE_STATUS_BAD; // RULE_14
              end
            end
          ST_REPLY:
            if (link.rd_req && reply_left != 2'h0) begin
              link.rd_valid <= 1'b1;
              link.rd_byte  <= reply_a;
              reply_a       <= reply_b;
              reply_left    <= reply_left - 2'h1;
            end
          default: state <= ST_IDLE;
        endcase
        if (state == ST_CMD || state == ST_ROM) begin
          crc <= (state == ST_ROM) ? PACKET_CRC_ERROR_FLAG_INIT : crc; // RULE_16
          if (state == ST_CMD && take) begin
            crc <= packet_crc_error_flag_byte(PACKET_CRC_ERROR_FLAG_INIT, b);
          end
        end
      end
    end
  end

  assign link.wr_ready = wr_ready_q;
endmodule : bridge_device
`default_nettype wire

// ---- logic/bridge_host.sv ----
// Host end: issues reset, ROM select and device commands
`timescale 1ns/1ps
`default_nettype none
module bridge_host
  import bridge_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       arst_n,
  bridge_link_if.host     link,
  input  wire logic       req_valid,
  input  wire logic [7:0] req_cmd,
  input  wire logic [7:0] req_byte,
  input  wire logic       req_corrupt,
  input  wire logic       wake_req,
  output logic            busy,
  output logic            resp_valid,
  output logic [7:0]      resp_byte
);
  typedef enum logic [3:0] {
    H_IDLE  = 4'b0000,
    H_RST   = 4'b0001,
    H_ROM   = 4'b0010,
    H_CMD   = 4'b0011,
    H_ADDR  = 4'b0100,
    H_WLEN  = 4'b0101,
    H_WDATA = 4'b0110,
    H_RCNT  = 4'b0111,
    H_CRCL  = 4'b1000,
    H_CRCH  = 4'b1001,
    H_READ  = 4'b1010,
    H_WAIT  = 4'b1011
  } hstate_t;

  hstate_t     state;
  logic [7:0]  cmd;
  logic [7:0]  data;
  logic [15:0] crc;
  logic        corrupt;
  logic [1:0]  reads_left;
  logic [7:0]  out_byte;

  wire         sent     = link.wr_valid & link.wr_ready;
  wire [15:0]  crc_tx   = ~crc ^ {15'h0000, corrupt}; // RULE_10
  // Byte follows the select state, so it always pairs with wr_valid
  assign link.wr_byte = out_byte;

  always_comb begin
    unique case (state)
      H_ROM:   out_byte = ROM_SKIP; // RULE_06
      H_CMD:   out_byte = cmd;
      H_ADDR:  out_byte = data;
      H_WLEN:  out_byte = 8'h01;
      H_WDATA: out_byte = data;
      H_RCNT:  out_byte = 8'h01;
      H_CRCL:  out_byte = crc_tx[7:0];
      H_CRCH:  out_byte = crc_tx[15:8];
      default: out_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state          <= H_IDLE;
      cmd            <= 8'h00;
      data           <= 8'h00;
      crc            <= PACKET_CRC_ERROR_FLAG_INIT;
      corrupt        <= 1'b0;
      reads_left     <= 2'h0;
      busy           <= 1'b0;
      resp_valid     <= 1'b0;
      resp_byte      <= 8'h00;
      link.bus_reset <= 1'b0;
      link.wr_valid  <= 1'b0;
      link.rd_req    <= 1'b0;
      link.wake      <= 1'b0;
    end else begin
      link.bus_reset <= 1'b0;
      link.rd_req    <= 1'b0;
      resp_valid     <= 1'b0;
      link.wake      <= wake_req; // RULE_03
      if (link.rd_valid) begin
        resp_valid <= 1'b1;
        resp_byte  <= link.rd_byte;
        reads_left <= reads_left - 2'h1;
      end
      unique case (state)
        H_IDLE:
          if (req_valid) begin
            cmd            <= req_cmd;
            data           <= req_byte;
            corrupt        <= req_corrupt;
            busy           <= 1'b1;
            link.bus_reset <= 1'b1; // RULE_06
            state          <= H_RST;
          end
        H_RST:
          if (link.presence) begin
            state        <= H_ROM;
            link.wr_valid <= 1'b1;
          end
        H_READ:
          if (reads_left == 2'h0) begin
            busy  <= 1'b0;
            state <= H_IDLE;
          end else if (!link.rd_valid && !link.rd_req) begin
            // Skip a cycle so a request never meets its own answer
            link.rd_req <= 1'b1;
          end
        H_WAIT: ;
        default:
          if (sent) begin
            if (state == H_CMD) begin
              crc <= packet_crc_error_flag_byte(PACKET_CRC_ERROR_FLAG_INIT, cmd); // RULE_16
            end else if (state == H_ADDR) begin
              crc <= packet_crc_error_flag_byte(crc, {data[7:1], 1'b0}); // RULE_13
            end else if (state inside {H_WLEN, H_WDATA, H_RCNT}) begin
              crc <= packet_crc_error_flag_byte(crc, out_byte); // RULE_09
            end
            if (state == H_CMD && cmd == CMD_SLEEP) begin
              // Sleep is write-only: no reads follow
              link.wr_valid <= 1'b0; // RULE_04
              busy          <= 1'b0;
              state         <= H_IDLE;
            end else if (state == H_CMD && cmd == CMD_REVISION) begin
              link.wr_valid <= 1'b0;
              reads_left    <= 2'h1;
              state         <= H_READ;
            end else if (state == H_CRCH) begin
              link.wr_valid <= 1'b0;
              reads_left    <= 2'h2;
              state         <= H_READ;
            end else begin
              state <= hstate_t'(state + 4'h1);
            end
          end
      endcase
    end
  end
endmodule : bridge_host
`default_nettype wire

// ---- logic/bridge_link_if.sv ----
// Byte-level link between host controller and bridge device
`timescale 1ns/1ps
`default_nettype none
interface bridge_link_if;
  logic       bus_reset;
  logic       presence;
  logic       wr_valid;
  logic [7:0] wr_byte;
  logic       wr_ready;
  logic       rd_req;
  logic       rd_valid;
  logic [7:0] rd_byte;
  logic       wake;

  modport device (input bus_reset, wr_valid, wr_byte, rd_req, wake,
                  output presence, wr_ready, rd_valid, rd_byte);
  modport host   (output bus_reset, wr_valid, wr_byte, rd_req, wake,
                  input presence, wr_ready, rd_valid, rd_byte);
endinterface : bridge_link_if
`default_nettype wire

// ---- logic/bridge_pkg.sv ----
// Shared constants for the bridge command block and its host end
package bridge_pkg;
  localparam logic [7:0]  CMD_SLEEP         = 8'h1E;
  localparam logic [7:0]  CMD_REVISION      = 8'hC3;
  localparam logic [7:0]  CMD_I2C_WRITE_READ = 8'h2D;
  localparam logic [7:0]  ROM_SKIP          = 8'hCC;
  localparam logic [3:0]  REV_MAJOR         = 4'h1;
  localparam logic [3:0]  REV_MINOR         = 4'h0;
  localparam logic [7:0]  CRC8_POLY_REFL    = 8'h8C;
  localparam logic [15:0] PACKET_CRC_ERROR_FLAG_POLY_REFL   = 16'hA001;
  localparam logic [15:0] PACKET_CRC_ERROR_FLAG_INIT        = 16'h0000;
  localparam logic [7:0]  CRC8_INIT         = 8'h00;
  localparam logic [7:0]  WRITE_STATUS_BAD  = 8'hFF;
  localparam int          STATUS_CRC_BIT    = 0;
  localparam logic [7:0]  STATUS_CLEAR      = 8'h00;

  function automatic logic [15:0] packet_crc_error_flag_byte(input logic [15:0] crc,
                                             input logic [7:0]  data);
    logic [15:0] c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ data[i]) ? ((c >> 1) ^ PACKET_CRC_ERROR_FLAG_POLY_REFL) : (c >> 1);
    end
    return c;
  endfunction : packet_crc_error_flag_byte

  function automatic logic [7:0] crc8_byte(input logic [7:0] crc,
                                           input logic [7:0] data);
    logic [7:0] c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ data[i]) ? ((c >> 1) ^ CRC8_POLY_REFL) : (c >> 1);
    end
    return c;
  endfunction : crc8_byte
endpackage : bridge_pkg

// ---- verif/bridge_link_sva.sv ----
// Link assertions between the host and device ends
`timescale 1ns/1ps
`default_nettype none
module bridge_link_sva
  import bridge_pkg::*;
(
  input wire logic       clock,
  input wire logic       arst_n,
  input wire logic       bus_reset,
  input wire logic       presence,
  input wire logic       wr_valid,
  input wire logic [7:0] wr_byte,
  input wire logic       wr_ready,
  input wire logic       rd_req,
  input wire logic       rd_valid,
  input wire logic       wake,
  input wire logic       sleeping,
  input wire logic       error_detected_out
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  sleep_quiet_a: assert property (
    sleeping |-> !presence && !wr_ready && !rd_valid)
    else $error("sleeping device answered");
  sleep_exit_a: assert property (
    $fell(sleeping) |-> $past(wake))
    else $error("sleep left without wake");
  wake_exits_a: assert property (
    $rose(wake) && sleeping |-> ##[1:3] !sleeping)
    else $error("wake edge did not end sleep");
  sleep_no_read_a: assert property (
    sleeping |-> !rd_req)
    else $error("read slot sent while asleep");
  error_hold_a: assert property (
    $fell(error_detected_out) |-> $past(bus_reset) || $past(bus_reset, 2))
    else $error("error output cleared without bus reset");
  presence_pulse_a: assert property (
    bus_reset && !sleeping |=> presence ##1 !presence)
    else $error("no presence pulse after bus reset");
  host_order_a: assert property (
    $rose(wr_valid) |-> wr_byte == ROM_SKIP && $past(presence))
    else $error("first byte not ROM select after presence");
  read_answer_a: assert property (
    rd_req |=> rd_valid)
    else $error("read request not answered");
endmodule : bridge_link_sva
`default_nettype wire

// ---- verif/testbench.sv ----
// Bench joining host and device ends over the link
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import bridge_pkg::*;
  logic        clock = 0;
  logic        arst_n = 0;
  logic        req_valid = 0;
  logic [7:0]  req_cmd = 0;
  logic [7:0]  req_byte = 0;
  logic        req_corrupt = 0;
  logic        wake_req = 0;
  logic [55:0] node_serial = 56'h00A1B2C3D4E5F6;
  logic        busy, resp_valid, error_detected_out, sleeping;
  logic        i2c_go;
  logic [7:0]  resp_byte, i2c_address;
  logic [63:0] node_identifier;
  logic [7:0]  rq[$];
  logic [7:0]  wq[$];
  logic [15:0] c;
  int          num_errors = 0;
  int          checks = 0;
  int          gos = 0;
  always #2.5 clock = ~clock;
  bridge_link_if bridge_link_if_inst ();
  bridge_device bridge_device_inst (.clock(clock), .arst_n(arst_n),
    .link(bridge_link_if_inst.device), .node_serial(node_serial),
    .error_detected_out(error_detected_out), .sleeping(sleeping),
    .i2c_go(i2c_go), .i2c_address(i2c_address),
    .node_identifier(node_identifier));
  bridge_host bridge_host_inst (.clock(clock), .arst_n(arst_n),
    .link(bridge_link_if_inst.host), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_byte(req_byte), .req_corrupt(req_corrupt),
    .wake_req(wake_req), .busy(busy), .resp_valid(resp_valid),
    .resp_byte(resp_byte));
  bridge_link_sva bridge_link_sva_inst (.clock(clock), .arst_n(arst_n),
    .bus_reset(bridge_link_if_inst.bus_reset),
    .presence(bridge_link_if_inst.presence),
    .wr_valid(bridge_link_if_inst.wr_valid),
    .wr_byte(bridge_link_if_inst.wr_byte),
    .wr_ready(bridge_link_if_inst.wr_ready),
    .rd_req(bridge_link_if_inst.rd_req),
    .rd_valid(bridge_link_if_inst.rd_valid),
    .wake(bridge_link_if_inst.wake), .sleeping(sleeping),
    .error_detected_out(error_detected_out));
  // Collect replies, accepted link bytes and transfer starts
  always @(posedge clock) begin
    if (resp_valid === 1'b1) rq.push_back(resp_byte);
    if (bridge_link_if_inst.wr_valid === 1'b1 &&
        bridge_link_if_inst.wr_ready === 1'b1)
      wq.push_back(bridge_link_if_inst.wr_byte);
    if (i2c_go === 1'b1) gos <= gos + 1;
  end
  // Reflected shift, LSB first; an 8-bit CRC rides in the low byte
  function automatic logic [15:0] crc(input logic [15:0] r,
                                      input logic [7:0]  d,
                                      input logic [15:0] p);
    for (int i = 0; i < 8; i++) r = (r[0] ^ d[i]) ? (r >> 1) ^ p : r >> 1;
    return r;
  endfunction : crc
  task automatic summarize;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t byte %h want %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t flag %b want %b", $time, got, exp);
    end
  endtask : chk1
  // One host request; waits for busy to fall under a bound
  task automatic run(input logic [7:0] cmd, input logic [7:0] b,
                     input logic k, input int n);
    int i;
    rq.delete();
    wq.delete();
    @(posedge clock);
    req_valid <= 1'b1;
    req_cmd <= cmd;
    req_byte <= b;
    req_corrupt <= k;
    @(posedge clock);
    req_valid <= 1'b0;
    for (i = 0; i < 600 && (i < 3 || busy !== 1'b0); i++) @(posedge clock);
    if (i == 600) begin
      num_errors++;
      $display("CHECK FAILED %0t host stuck busy", $time);
      summarize();
    end
    repeat (3) @(posedge clock);
    chk8(8'(rq.size()), 8'(n));
    $display("request %h done", cmd);
  endtask : run
  initial begin
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    c = 16'h0000;
    for (int k = 0; k < 7; k++) c = crc(c, node_serial[8*k+:8], 16'h008C);
    chk8(node_identifier[63:56], c[7:0]);
    chk8(node_identifier[7:0], node_serial[7:0]);
    run(CMD_REVISION, 8'h00, 1'b0, 1);
    chk8(rq[0], {REV_MAJOR, REV_MINOR});
    run(CMD_I2C_WRITE_READ, 8'h51, 1'b0, 2);
    chk8(rq[0], STATUS_CLEAR);
    chk8(rq[1], 8'h00);
    chk8(8'(gos), 8'h01);
    chk8(i2c_address, 8'h51);
    chk1(error_detected_out, 1'b0);
    chk8(wq[0], ROM_SKIP);
    // Odd address shows that its low bit is left out of the sum
    c = PACKET_CRC_ERROR_FLAG_INIT;
    for (int k = 1; k < 6; k++)
      c = crc(c, (k == 2) ? wq[k] & 8'hFE : wq[k], PACKET_CRC_ERROR_FLAG_POLY_REFL);
    chk8(wq[6], ~c[7:0]);
    chk8(wq[7], ~c[15:8]);
    run(CMD_I2C_WRITE_READ, 8'h51, 1'b1, 2);
    chk8(rq[0], 8'(1 << STATUS_CRC_BIT));
    chk8(rq[1], WRITE_STATUS_BAD);
    chk8(8'(gos), 8'h01);
    chk1(error_detected_out, 1'b1);
    repeat (20) @(posedge clock);
    chk1(error_detected_out, 1'b1);
    run(CMD_REVISION, 8'h00, 1'b0, 1);
    chk1(error_detected_out, 1'b0);
    run(CMD_SLEEP, 8'h00, 1'b0, 0);
    chk1(sleeping, 1'b1);
    repeat (30) @(posedge clock);
    chk1(sleeping, 1'b1);
    wake_req <= 1'b1;
    for (int i = 0; i < 10 && sleeping !== 1'b0; i++) @(posedge clock);
    chk1(sleeping, 1'b0);
    wake_req <= 1'b0;
    run(CMD_REVISION, 8'h00, 1'b0, 1);
    chk8(rq[0], {REV_MAJOR, REV_MINOR});
    summarize();
  end
endmodule : testbench
`default_nettype wire
